// ==== src/led_duty_regs.sv ====
// file: apb register bank with the 12-bit duty settings of 12 led channels
// assumes the stored duty copies are static and on the mclk domain
// and an apb master that holds each request until pready is high
`timescale 1ns/1ps

// What this block does
// - channels 1-11 upper byte registers, read/write
// - upper register at index 20h+n drives channel n
// - upper registers load stored copy after reset
// - channel zero lower nibble resets to all ones
// - lower register own index, bits 7-4 read zero
// - channel zero upper register loads stored copy
// - lower registers for channels 1-11 follow consecutively
module led_duty_regs (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire duty_pkg::apb_req_t apb_req,
    output duty_pkg::apb_rsp_t apb_rsp,
    // nonvolatile copies of the upper duty bytes
    input wire duty_pkg::high_t [duty_pkg::NUM_CH-1:0] stored_duty_copy,
    // duty values to the pwm generators
    output duty_pkg::duty_t [duty_pkg::NUM_CH-1:0] duty
);

    // decode a byte address into channel and upper or lower register
    function automatic duty_pkg::dec_t decode(
        input logic [duty_pkg::ADDR_W-1:0] addr
    );
        duty_pkg::dec_t d;
        logic [9:0] idx;
        d = '0;
        idx = addr[duty_pkg::ADDR_W-1:2];
        if (addr[1:0] != 2'h0) begin
            d.hit = 1'b0;               // unaligned byte address
        end else if (idx >= duty_pkg::IDX_DUTY_HIGH_CH0 &&
                     idx <= duty_pkg::IDX_DUTY_HIGH_CH11) begin
            d.hit = 1'b1;               // upper byte block
            d.ch = 4'(idx - duty_pkg::IDX_DUTY_HIGH_CH0);
        end else if (idx >= duty_pkg::IDX_DUTY_LOW_CH0 &&
                     idx < duty_pkg::IDX_DUTY_LOW_CH0 + 10'(duty_pkg::NUM_CH))
                     begin
            d.hit = 1'b1;               // lower nibble block
            d.is_low = 1'b1;
            d.ch = 4'(idx - duty_pkg::IDX_DUTY_LOW_CH0);
        end
        return d;
    endfunction

    // register state
    duty_pkg::high_t [duty_pkg::NUM_CH-1:0] high;  // upper duty bytes
    duty_pkg::low_t [duty_pkg::NUM_CH-1:0] low;    // lower duty nibbles
    logic load_pending;                           // stored copy not yet taken
    duty_pkg::high_t [duty_pkg::NUM_CH-1:0] next_high;
    duty_pkg::low_t [duty_pkg::NUM_CH-1:0] next_low;
    logic next_load_pending;
    // bus answer state
    duty_pkg::apb_rsp_t next_rsp;
    duty_pkg::duty_t [duty_pkg::NUM_CH-1:0] next_duty;
    // decoded request and handshake terms
    duty_pkg::dec_t dec;
    logic access_done;                            // transfer ends this edge
    logic wr_en;                                  // write takes effect

    assign dec = decode(apb_req.paddr);
    assign access_done = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign wr_en = access_done && apb_req.pwrite && dec.hit;

    // next values of the duty registers
    always_comb begin
        next_high = high;
        next_low = low;
        next_load_pending = 1'b0;
        if (load_pending) begin
            // first edge after reset: take the stored copies
            next_high = stored_duty_copy;
        end else if (wr_en) begin
            if (dec.is_low) begin
                // lower nibble only, upper bits are reserved
                next_low[dec.ch] =
                    apb_req.pwdata[duty_pkg::LOW_W-1:0];
            end else begin
                // whole upper byte
                next_high[dec.ch] =
                    apb_req.pwdata[duty_pkg::HIGH_W-1:0];
            end
        end
    end

    // duty registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            high <= {duty_pkg::NUM_CH{duty_pkg::HIGH_RESET}};
            low <= {duty_pkg::NUM_CH{duty_pkg::LOW_RESET}};
            load_pending <= 1'b1;
        end else begin
            high <= next_high;
            low <= next_low;
            load_pending <= next_load_pending;
        end
    end

    // next apb answer: ready one cycle after the request is seen
    always_comb begin
        next_rsp = '0;
        if (apb_req.psel && !apb_rsp.pready && !load_pending) begin
            // answer stands for exactly one cycle
            next_rsp.pready = 1'b1;
            next_rsp.pslverr = !dec.hit;
            if (dec.hit && !apb_req.pwrite) begin
                if (dec.is_low) begin
                    // reserved bits 7-4 and above read as zero
                    next_rsp.prdata = duty_pkg::RESERVED_READ |
                                      32'(low[dec.ch]);
                end else begin
                    next_rsp.prdata = duty_pkg::RESERVED_READ |
                                      32'(high[dec.ch]);
                end
            end
        end
    end

    // next duty outputs: upper byte above the lower nibble
    always_comb begin
        for (int i = 0; i < duty_pkg::NUM_CH; i++) begin
            next_duty[i] = {high[i], low[i]};
        end
    end

    // apb answer and duty output registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            apb_rsp <= '0;
            duty <= '0;
        end else begin
            apb_rsp <= next_rsp;
            duty <= next_duty;
        end
    end

    // checks on the bank
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // a write access completing on a mapped register
    sequence high_write_s;
        wr_en && !dec.is_low;
    endsequence

    sequence low_write_s;
        wr_en && dec.is_low;
    endsequence

    high_write_a: assert property (
        high_write_s |=> high[$past(dec.ch)] == $past(apb_req.pwdata[7:0]))
        else $error("upper duty write not stored");

    low_write_a: assert property (
        low_write_s |=> low[$past(dec.ch)] == $past(apb_req.pwdata[3:0]))
        else $error("lower duty write not stored");

    write_to_pin_a: assert property (
        high_write_s |-> ##2
        duty[$past(dec.ch, 2)][11:4] == $past(apb_req.pwdata[7:0], 2))
        else $error("upper write did not reach its channel");

    stored_load_a: assert property (
        $fell(load_pending) |-> high == $past(stored_duty_copy))
        else $error("stored duty copy not loaded");

    low_reset_a: assert property (
        load_pending |-> low == {duty_pkg::NUM_CH{duty_pkg::LOW_RESET}}
        && !apb_rsp.pready)
        else $error("lower nibble not all ones after reset");

    reserved_zero_a: assert property (
        apb_rsp.pready && $past(dec.is_low && dec.hit && !apb_req.pwrite)
        |-> apb_rsp.prdata[31:4] == 28'h0000000
        && apb_rsp.prdata[3:0] == $past(low[dec.ch]))
        else $error("lower register read wrong");

    concat_a: assert property (
        1'b1 |=> duty[0] == {$past(high[0]), $past(low[0])})
        else $error("duty not formed as upper then lower");

    ready_time_a: assert property (
        apb_req.psel && !apb_req.penable && !load_pending
        |-> ##[1:2] apb_rsp.pready)
        else $error("apb answer late");

    unmapped_err_a: assert property (
        apb_req.psel && !apb_rsp.pready && !load_pending && !dec.hit
        |=> apb_rsp.pready && apb_rsp.pslverr)
        else $error("unmapped access not flagged");

    // further checks: answer timing, refused accesses, and that nothing
    // but a write or the stored copy load ever moves a register

    // an answer on the bus
    sequence answer_s;
        apb_rsp.pready;
    endsequence

    // a read answered for a mapped upper byte register
    sequence high_read_s;
        apb_rsp.pready &&
        $past(dec.hit && !dec.is_low && !apb_req.pwrite);
    endsequence

    // a write answered, whatever its address
    sequence write_answer_s;
        apb_rsp.pready && $past(apb_req.pwrite);
    endsequence

    // an access that ends on an address with no register behind it
    sequence refused_s;
        access_done && !dec.hit;
    endsequence

    // a request seen while no answer is pending and the load is done
    sequence setup_s;
        apb_req.psel && !apb_rsp.pready && !load_pending;
    endsequence

    // the answer stands one cycle, so a held request is not acked twice
    ready_pulse_a: assert property (
        answer_s |=> !apb_rsp.pready)
        else $error("apb answer stood longer than one cycle");

    // the upper byte read back is the one held at that index
    high_read_a: assert property (
        high_read_s |->
        apb_rsp.prdata == {24'h000000, $past(high[dec.ch])})
        else $error("upper duty read wrong");

    // writes return no data on the read lines
    write_data_zero_a: assert property (
        write_answer_s |-> apb_rsp.prdata == 32'h00000000)
        else $error("read data not zero on a write answer");

    // a refused access leaves every register as it was
    err_no_write_a: assert property (
        refused_s |=> high == $past(high) && low == $past(low))
        else $error("refused access changed a register");

    // the error flag only ever comes together with the answer
    err_with_ready_a: assert property (
        apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error flag without an answer");

    // a mapped address is never flagged as an error
    mapped_no_err_a: assert property (
        apb_rsp.pready && $past(dec.hit) |-> !apb_rsp.pslverr)
        else $error("mapped access flagged as error");

    // registers change only by a completed write or the load
    no_stray_write_a: assert property (
        !wr_en && !load_pending |=>
        high == $past(high) && low == $past(low))
        else $error("register changed without a write");

    // upper bytes hold their reset value until the load edge
    load_wait_a: assert property (
        load_pending |-> high == {duty_pkg::NUM_CH{duty_pkg::HIGH_RESET}})
        else $error("upper byte changed before the load");

    // the load happens once per reset, never in normal running
    load_once_a: assert property (
        !load_pending |=> !load_pending)
        else $error("stored copy load repeated");

    // a lower nibble write reaches the low bits of its channel
    low_to_pin_a: assert property (
        low_write_s |-> ##2
        duty[$past(dec.ch, 2)][3:0] == $past(apb_req.pwdata[3:0], 2))
        else $error("lower write did not reach its channel");

    // the last channel is formed the same way as channel zero
    concat_last_a: assert property (
        1'b1 |=> duty[11] ==
        {$past(high[11]), $past(low[11])})
        else $error("last duty not formed as upper then lower");

    // every accepted request is answered on the next edge
    ready_next_a: assert property (
        setup_s |=> apb_rsp.pready)
        else $error("apb answer missing after request");

    // an upper byte write leaves the lower nibbles alone
    high_keeps_low_a: assert property (
        high_write_s |=> low == $past(low))
        else $error("upper write changed a lower nibble");

    // a lower nibble write leaves the upper bytes alone
    low_keeps_high_a: assert property (
        low_write_s |=> high == $past(high))
        else $error("lower write changed an upper byte");

    // an unaligned byte address is refused
    unaligned_err_a: assert property (
        apb_req.psel && !apb_rsp.pready && !load_pending &&
        apb_req.paddr[1:0] != 2'h0 |=> apb_rsp.pslverr)
        else $error("unaligned access not flagged");

endmodule // led_duty_regs

// ==== inc/duty_pkg.sv ====
// package: map, field layout and reset values of the duty register bank
// assumes a 32-bit apb master; register index times four is the byte address
package duty_pkg;
    localparam int NUM_CH = 12;               // channels served
    localparam int ADDR_W = 12;               // apb byte address width
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_DUTY_HIGH_CH0 = 10'h020;
    localparam logic [9:0] IDX_DUTY_HIGH_CH1 = 10'h021;
    localparam logic [9:0] IDX_DUTY_HIGH_CH2 = 10'h022;
    localparam logic [9:0] IDX_DUTY_HIGH_CH3 = 10'h023;
    localparam logic [9:0] IDX_DUTY_HIGH_CH4 = 10'h024;
    localparam logic [9:0] IDX_DUTY_HIGH_CH5 = 10'h025;
    localparam logic [9:0] IDX_DUTY_HIGH_CH6 = 10'h026;
    localparam logic [9:0] IDX_DUTY_HIGH_CH7 = 10'h027;
    localparam logic [9:0] IDX_DUTY_HIGH_CH8 = 10'h028;
    localparam logic [9:0] IDX_DUTY_HIGH_CH9 = 10'h029;
    localparam logic [9:0] IDX_DUTY_HIGH_CH10 = 10'h02a;
    localparam logic [9:0] IDX_DUTY_HIGH_CH11 = 10'h02b;
    localparam logic [9:0] IDX_DUTY_LOW_CH0 = 10'h040;
    localparam logic [9:0] IDX_DUTY_LOW_CH1 = 10'h041;
    // field layout
    localparam int HIGH_W = 8;                // upper field, bits 7-0
    localparam int LOW_W = 4;                 // lower nibble, bits 3-0
    // values after reset
    localparam logic [7:0] HIGH_RESET = 8'h00;  // until the stored copy loads
    localparam logic [3:0] LOW_RESET = 4'hf;    // lower nibble all ones
    localparam logic [31:0] RESERVED_READ = 32'h0000_0000;

    typedef logic [HIGH_W-1:0] high_t;
    typedef logic [LOW_W-1:0] low_t;
    typedef logic [HIGH_W+LOW_W-1:0] duty_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // address decode result
    typedef struct packed {
        logic hit;
        logic is_low;
        logic [3:0] ch;
    } dec_t;
endpackage

// ==== test/led_duty_regs_tb.sv ====
// testbench: apb read and write tests of the led duty register bank
// assumes duty_pkg and led_duty_regs are compiled before this file
`timescale 1ns/1ps
`define CHK(nm, ex, got) tests_run++; \
    if ((got) !== (ex)) begin \
        err_total++; \
        $display("Error %s expected %h seen %h", nm, ex, got); \
    end

module led_pwm_duty_register_bank_tb_top;
    // clock, reset and design ports
    logic mclk;
    logic rst;
    duty_pkg::apb_req_t apb_req;
    duty_pkg::apb_rsp_t apb_rsp;
    duty_pkg::high_t [duty_pkg::NUM_CH-1:0] stored_duty_copy;
    duty_pkg::duty_t [duty_pkg::NUM_CH-1:0] duty;
    // bookkeeping
    int err_total;
    int tests_run;
    logic [31:0] rd;
    logic err;
    logic [7:0] w;

    led_duty_regs u_dut (
        .mclk(mclk),
        .rst(rst),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .stored_duty_copy(stored_duty_copy),
        .duty(duty)
    );

    // free running 10 mhz clock
    always #50 mclk = ~mclk;

    // verdict and end of run
    task automatic report_and_stop();
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one apb transfer to a byte address: setup, access, bounded wait
    task automatic xfer_addr(input logic wr, input logic [11:0] addr,
                             input logic [31:0] wd);
        int n;
        @(posedge mclk);
        apb_req <= '{1'b1, 1'b0, wr, addr, wd};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (apb_rsp.pready !== 1'b1) begin
            err_total++;
            report_and_stop();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // one apb transfer to a register index
    task automatic xfer(input logic wr, input logic [9:0] idx,
                        input logic [31:0] wd);
        xfer_addr(wr, {idx, 2'b00}, wd);
    endtask

    // all registers and duty outputs after a reset
    task automatic check_reset();
        for (int n = 0; n < duty_pkg::NUM_CH; n++) begin
            xfer(1'b0, 10'h020 + 10'(n), 32'h0);
            `CHK("high reset", {24'h0, stored_duty_copy[n]}, rd)
            xfer(1'b0, 10'h040 + 10'(n), 32'h0);
            `CHK("low reset", 32'h0000_000f, rd)
            `CHK("duty reset", {stored_duty_copy[n], 4'hf}, duty[n])
        end
    endtask

    // main sequence
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        apb_req = '0;
        err_total = 0;
        tests_run = 0;
        for (int n = 0; n < duty_pkg::NUM_CH; n++) begin
            stored_duty_copy[n] = 8'ha0 + 8'(n * 5);
        end
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        check_reset();
        // upper bytes of channels 1 to 11 with distinct values
        for (int n = 1; n < duty_pkg::NUM_CH; n++) begin
            xfer(1'b1, 10'h020 + 10'(n), {24'h0, 8'h5a ^ 8'(n)});
        end
        for (int n = 1; n < duty_pkg::NUM_CH; n++) begin
            w = 8'h5a ^ 8'(n);
            xfer(1'b0, 10'h020 + 10'(n), 32'h0);
            `CHK("high rw", {24'h0, w}, rd)
            `CHK("duty high", {w, 4'hf}, duty[n])
        end
        `CHK("duty ch0 kept", {stored_duty_copy[0], 4'hf}, duty[0])
        // channel zero upper byte at its own index
        xfer(1'b1, duty_pkg::IDX_DUTY_HIGH_CH0, 32'h0000_0077);
        xfer(1'b0, duty_pkg::IDX_DUTY_HIGH_CH0, 32'h0);
        `CHK("high ch0 rw", 32'h0000_0077, rd)
        `CHK("duty ch0 high", {8'h77, 4'hf}, duty[0])
        // lower nibbles: reserved bits dropped
        xfer(1'b1, duty_pkg::IDX_DUTY_LOW_CH0, 32'hffff_ffa5);
        xfer(1'b1, duty_pkg::IDX_DUTY_LOW_CH1, 32'h0000_0003);
        xfer(1'b0, duty_pkg::IDX_DUTY_LOW_CH0, 32'h0);
        `CHK("low ch0 read", 32'h0000_0005, rd)
        `CHK("duty ch0 low", {8'h77, 4'h5}, duty[0])
        `CHK("duty ch1", {8'h5b, 4'h3}, duty[1])
        xfer(1'b0, duty_pkg::IDX_DUTY_LOW_CH1, 32'h0);
        `CHK("low ch1 read", 32'h0000_0003, rd)
        // unmapped index and unaligned write are refused
        xfer(1'b0, 10'h02c, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        xfer_addr(1'b1, 12'h085, 32'h0000_0011);
        `CHK("unaligned err", 1'b1, err)
        xfer(1'b0, duty_pkg::IDX_DUTY_HIGH_CH1, 32'h0);
        `CHK("unaligned kept", 32'h0000_005b, rd)
        // new stored copies, then a reset in mid run reloads them
        @(posedge mclk);
        for (int n = 0; n < duty_pkg::NUM_CH; n++) begin
            stored_duty_copy[n] <= 8'h30 + 8'(n * 7);
        end
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        check_reset();
        report_and_stop();
    end
endmodule // led_pwm_duty_register_bank_tb_top
